// file: hw/kpi_pkg.sv
// constants for the key pin interrupt unit: register map, field positions, reset values
// assumes an avalon-mm slave with 32-bit data and word addresses, one per register
//
// Summary of operation
// RQ1: eight-source architecture; only the lowest four pin inputs are implemented.
// RQ2: each pin enable bit makes its input an interrupt source when set.
// RQ3: mode bit 0 selects edge-only (0) or edge-plus-level (1) for all pins.
// RQ4: polarity bit clear means falling/low, set means rising/high.
// RQ5: falling edge is high in one bus cycle, low in the next.
// RQ6: rising edge is low in one bus cycle, high in the next.
// RQ7: after an edge, no new edge until all enabled inputs deassert.
// RQ8: external source holds enabled inputs deasserted before the first edge.
// RQ9: in edge-only mode a valid edge sets the flag at bit 3.
// RQ10: in edge-plus-level mode an edge or asserted level sets the flag.
// RQ11: interrupt request is flag and enable bit 1 together.
// RQ12: writes to the flag position have no effect; only acknowledge clears.
// RQ13: writing 1 to acknowledge bit 2 clears the flag; it reads 0.
// RQ14: in level mode an acknowledge leaves the flag set while any pin asserted; the code holds it only while an enabled pin is asserted.
// RQ15: status/control bits 7 to 4 read as zero.
// RQ16: unit keeps running in wait mode and its request wakes the processor.
// RQ17: in shallow stop pin events wake the processor without a clock.
// RQ18: in the deeper stops the unit is off and returns to reset on wake.
// RQ19: in background debug mode the unit operates normally.
// RQ20: polarity bit chooses pull-up (0) or pull-down (1) for an enabled pin.
// RQ21: software initialises in order: mask, polarity, pulls, enable, ack, unmask.
// RQ22: each input passes a two-flop synchroniser before edge comparison.
package kpi_pkg;
    localparam int KPI_PINS = 4;
    localparam int KPI_ARCH_PINS = 8;
    localparam logic [1:0] KPI_ADDR_STATUS_CONTROL = 2'h0;
    localparam logic [1:0] KPI_ADDR_PIN_ENABLE = 2'h1;
    localparam logic [1:0] KPI_ADDR_POLARITY_SELECT = 2'h2;
    localparam int KPI_BIT_MODE = 0;
    localparam int KPI_BIT_IRQ_EN = 1;
    localparam int KPI_BIT_ACK = 2;
    localparam int KPI_BIT_FLAG = 3;
    localparam logic [7:0] KPI_RESET_BYTE = 8'h00;
    localparam logic [31:0] KPI_UNMAPPED_READ = 32'h0000_0000;
endpackage : kpi_pkg

// file: hw/kpi_key_pin_interrupt.sv
// key pin interrupt unit: four watched pins, one shared event flag, one request
// assumes pins are already synchronous to clk per system convention; still double-flopped
`timescale 1ns/1ns
`default_nettype none
module kpi_key_pin_interrupt
    import kpi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [KPI_PINS-1:0] watched_input_pin,
    input wire logic shallow_stop,
    output logic irq,
    output logic wake_request,
    output logic [KPI_PINS-1:0] pin_pull_select
);
    logic [7:0] key_pin_enable_reg;
    logic [7:0] key_polarity_select_reg;
    logic detect_mode_select_reg;
    logic pin_irq_enable_reg;
    logic pin_event_flag_reg;
    logic [KPI_PINS-1:0] sync1_reg;
    logic [KPI_PINS-1:0] sync2_reg;
    logic [KPI_PINS-1:0] asserted_prev_reg;
    logic edge_armed_reg;
    logic [31:0] avs_readdata_reg;
    logic ack_pend_reg;
    logic [KPI_PINS-1:0] asserted;
    logic [KPI_PINS-1:0] enabled_asserted;
    logic any_asserted;
    logic edge_hit;
    logic flag_set;
    logic wr_status;
    logic ack_write;

    // bus: one wait cycle on every access, answer at the second edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ack_pend_reg <= 1'b0;
        end else if (clk_en) begin
            ack_pend_reg <= (avs_read || avs_write) && !ack_pend_reg;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack_pend_reg;

    assign wr_status = avs_write && ack_pend_reg && clk_en && avs_byteenable[0]
        && avs_address == KPI_ADDR_STATUS_CONTROL;
    assign ack_write = wr_status && avs_writedata[KPI_BIT_ACK]; // RQ13

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            key_pin_enable_reg <= KPI_RESET_BYTE;
            key_polarity_select_reg <= KPI_RESET_BYTE;
            detect_mode_select_reg <= 1'b0;
            pin_irq_enable_reg <= 1'b0;
        end else if (clk_en && avs_write && ack_pend_reg && avs_byteenable[0]) begin
            unique case (avs_address)
                KPI_ADDR_STATUS_CONTROL: begin
                    detect_mode_select_reg <= avs_writedata[KPI_BIT_MODE]; // RQ3
                    pin_irq_enable_reg <= avs_writedata[KPI_BIT_IRQ_EN];
                end
                KPI_ADDR_PIN_ENABLE: key_pin_enable_reg <= avs_writedata[7:0]; // RQ2
                KPI_ADDR_POLARITY_SELECT: key_polarity_select_reg <= avs_writedata[7:0]; // RQ4
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            avs_readdata_reg <= KPI_UNMAPPED_READ;
        end else if (clk_en && avs_read && !ack_pend_reg) begin
            unique case (avs_address)
                KPI_ADDR_STATUS_CONTROL: avs_readdata_reg <= {28'h000_0000,
                    pin_event_flag_reg, 1'b0, pin_irq_enable_reg,
                    detect_mode_select_reg}; // RQ15 RQ13
                KPI_ADDR_PIN_ENABLE: avs_readdata_reg <= {24'h00_0000, key_pin_enable_reg};
                KPI_ADDR_POLARITY_SELECT: avs_readdata_reg <= {24'h00_0000,
                    key_polarity_select_reg};
                default: avs_readdata_reg <= KPI_UNMAPPED_READ;
            endcase
        end
    end
    assign avs_readdata = avs_readdata_reg;

    // upper four enable and polarity bits are storage only: no pins behind them
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (clk_en) begin
            sync1_reg <= watched_input_pin; // RQ22
            sync2_reg <= sync1_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < KPI_PINS; g++) begin : g_pin // RQ1
            assign asserted[g] = sync2_reg[g] ~^ key_polarity_select_reg[g]; // RQ4
            assign enabled_asserted[g] = asserted[g] && key_pin_enable_reg[g];
            assign pin_pull_select[g] = key_polarity_select_reg[g]; // RQ20
        end
    endgenerate
    assign any_asserted = |enabled_asserted;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            asserted_prev_reg <= '0;
            edge_armed_reg <= 1'b1;
        end else if (clk_en) begin
            asserted_prev_reg <= asserted;
            // re-arm only when every enabled input is back at deasserted level
            if (edge_hit) begin
                edge_armed_reg <= 1'b0; // RQ7
            end else if (!any_asserted) begin
                edge_armed_reg <= 1'b1;
            end
        end
    end
    // deasserted in one cycle, asserted in the next, on an enabled pin
    assign edge_hit = edge_armed_reg
        && |(enabled_asserted & ~asserted_prev_reg); // RQ5 RQ6
    assign flag_set = edge_hit || (detect_mode_select_reg && any_asserted); // RQ9 RQ10

    // a set in the same cycle as the acknowledge wins
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_event_flag_reg <= 1'b0; // RQ18
        end else if (clk_en) begin
            if (flag_set) begin
                pin_event_flag_reg <= 1'b1; // RQ14
            end else if (ack_write) begin
                pin_event_flag_reg <= 1'b0; // RQ12
            end
        end
    end

    assign irq = pin_event_flag_reg && pin_irq_enable_reg; // RQ11 RQ16 RQ19
    // shallow stop: clockless path straight from the pins, gated by stored config
    assign wake_request = irq || (shallow_stop && pin_irq_enable_reg
        && |(key_pin_enable_reg[KPI_PINS-1:0]
        & (watched_input_pin ~^ key_polarity_select_reg[KPI_PINS-1:0]))); // RQ17

    a_irq_follows_flag: assert property (@(posedge clk) disable iff (!rst_b)
        irq == (pin_event_flag_reg && pin_irq_enable_reg))
        else $error("irq not flag and enable"); // RQ11
    a_edge_sets_flag: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && edge_hit |=> pin_event_flag_reg)
        else $error("edge did not set flag"); // RQ9
    a_level_holds_flag: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && detect_mode_select_reg && any_asserted && ack_write |=> pin_event_flag_reg)
        else $error("ack cleared flag while level asserted"); // RQ14
    a_ack_clears_flag: assert property (@(posedge clk) disable iff (!rst_b)
        ack_write && !flag_set |=> !pin_event_flag_reg)
        else $error("ack did not clear flag"); // RQ13
    a_flag_only_by_ack: assert property (@(posedge clk) disable iff (!rst_b)
        pin_event_flag_reg && !ack_write |=> pin_event_flag_reg)
        else $error("flag cleared without ack"); // RQ12
    a_no_rearm_early: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && edge_hit ##1 (clk_en && any_asserted) |=> !edge_armed_reg)
        else $error("edge rearmed while input asserted"); // RQ7
    a_upper_reads_zero: assert property (@(posedge clk) disable iff (!rst_b)
        avs_read && !avs_waitrequest && avs_address == KPI_ADDR_STATUS_CONTROL
        |-> avs_readdata[7:4] == 4'h0 && !avs_readdata[KPI_BIT_ACK])
        else $error("status upper or ack bit read nonzero"); // RQ15
    // stage by stage, so the reset values held in the chain never look like a fault
    a_sync_delay: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en |=> sync1_reg == $past(watched_input_pin) && sync2_reg == $past(sync1_reg))
        else $error("synchroniser depth wrong"); // RQ22
    a_disabled_pin_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        key_pin_enable_reg[KPI_PINS-1:0] == 4'h0 |-> !flag_set)
        else $error("disabled pins set flag"); // RQ2

    // bus steps: a request first meets a wait cycle, then is accepted
    sequence s_req_waiting;
        clk_en && (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_write_taken;
        clk_en && avs_write && !avs_waitrequest && avs_byteenable[0];
    endsequence
    sequence s_read_first(logic [1:0] adr);
        clk_en && avs_read && avs_waitrequest && avs_address == adr;
    endsequence
    // pin steps: an armed idle cycle, then an enabled pin asserts with setup unchanged
    sequence s_idle_armed;
        clk_en && edge_armed_reg && !any_asserted;
    endsequence
    sequence s_pin_asserts;
        clk_en && any_asserted && $stable(key_pin_enable_reg)
            && $stable(key_polarity_select_reg);
    endsequence

    a_wait_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
        s_req_waiting ##1 (clk_en && (avs_read || avs_write)) |-> !avs_waitrequest)
        else $error("access not answered after one wait cycle");
    a_enable_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
        s_write_taken ##0 avs_address == KPI_ADDR_PIN_ENABLE
        |=> key_pin_enable_reg == $past(avs_writedata[7:0]))
        else $error("pin enable write lost"); // RQ2
    a_polarity_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
        s_write_taken ##0 avs_address == KPI_ADDR_POLARITY_SELECT
        |=> key_polarity_select_reg == $past(avs_writedata[7:0]))
        else $error("polarity write lost"); // RQ4
    a_control_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
        s_write_taken ##0 avs_address == KPI_ADDR_STATUS_CONTROL
        |=> detect_mode_select_reg == $past(avs_writedata[KPI_BIT_MODE])
        && pin_irq_enable_reg == $past(avs_writedata[KPI_BIT_IRQ_EN]))
        else $error("control write lost"); // RQ3
    a_config_holds: assert property (@(posedge clk) disable iff (!rst_b)
        !(avs_write && !avs_waitrequest && clk_en)
        |=> $stable(key_pin_enable_reg) && $stable(key_polarity_select_reg))
        else $error("configuration changed without a write"); // RQ2 RQ4
    a_enable_read_value: assert property (@(posedge clk) disable iff (!rst_b)
        s_read_first(KPI_ADDR_PIN_ENABLE) ##1 (avs_read && !avs_waitrequest)
        |-> avs_readdata == {24'h00_0000, $past(key_pin_enable_reg)})
        else $error("pin enable read wrong"); // RQ2
    // an unmapped word answers zero after the same one wait cycle as any access
    a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_b)
        avs_read && !avs_waitrequest && avs_address != KPI_ADDR_STATUS_CONTROL
        && avs_address != KPI_ADDR_PIN_ENABLE && avs_address != KPI_ADDR_POLARITY_SELECT
        |-> avs_readdata == KPI_UNMAPPED_READ)
        else $error("unmapped read nonzero"); // RQ15
    a_frozen_state: assert property (@(posedge clk) disable iff (!rst_b)
        !clk_en |=> $stable(pin_event_flag_reg) && $stable(sync2_reg)
        && $stable(edge_armed_reg))
        else $error("state moved while clock enable low"); // RQ22
    a_pin_edge_flags: assert property (@(posedge clk) disable iff (!rst_b)
        s_idle_armed ##1 s_pin_asserts |=> pin_event_flag_reg)
        else $error("pin edge did not set flag"); // RQ5 RQ6
    a_rearm_when_idle: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && !any_asserted |=> edge_armed_reg)
        else $error("edge detect not rearmed"); // RQ7
    a_level_sets_flag: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && detect_mode_select_reg && any_asserted |=> pin_event_flag_reg)
        else $error("asserted level did not set flag"); // RQ10
    a_edge_mode_quiet: assert property (@(posedge clk) disable iff (!rst_b)
        clk_en && !detect_mode_select_reg && !edge_hit && !pin_event_flag_reg
        |=> !pin_event_flag_reg)
        else $error("flag set without edge"); // RQ9
    a_flag_write_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        wr_status && !ack_write && !flag_set |=> $stable(pin_event_flag_reg))
        else $error("write changed flag"); // RQ12
    a_irq_wakes: assert property (@(posedge clk) disable iff (!rst_b)
        irq |-> wake_request)
        else $error("request without wake"); // RQ16
endmodule : kpi_key_pin_interrupt
`default_nettype wire

// file: bench/kpi_pin_model.sv
// switch model: drives the watched pins from a level commanded by the bench
// assumes the bench changes want just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module kpi_pin_model (
    input wire logic clk,
    input wire logic [3:0] want,
    output logic [3:0] pins
);
    // switches move on an edge; the bench keeps enabled pins idle before arming
    always_ff @(posedge clk) pins <= want;
endmodule : kpi_pin_model
`default_nettype wire

// file: bench/kpi_key_pin_interrupt_bench.sv
// self-checking bench for the key pin interrupt unit
// assumes a 50 MHz clock and a slave that answers within a few cycles
`timescale 1ns/1ns
`default_nettype none
module kpi_key_pin_interrupt_bench;
    import kpi_pkg::*;
    localparam logic [1:0] a_sc = KPI_ADDR_STATUS_CONTROL;
    localparam logic [1:0] a_pe = KPI_ADDR_PIN_ENABLE;
    localparam logic [1:0] a_pol = KPI_ADDR_POLARITY_SELECT;
    logic clk = 1'h0, rst_b = 1'h0, ce = 1'h1, rd = 1'h0, wr = 1'h0, stp = 1'h0;
    logic wait_r, irq, wake;
    logic [1:0] adr = 2'h0;
    logic [3:0] be = 4'h1, want = 4'hf, pins, pull;
    logic [31:0] wd = 32'h0000_0000, rdata, seed = 32'h0000_788a;
    logic [31:0] expq[$];
    int errors = 0, checked = 0;
    always #10 clk = ~clk;
    kpi_pin_model u_sw (.clk(clk), .want(want), .pins(pins));
    kpi_key_pin_interrupt u_dut (.clk(clk), .rst_b(rst_b), .clk_en(ce), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(wait_r), .watched_input_pin(pins),
        .shallow_stop(stp), .irq(irq), .wake_request(wake), .pin_pull_select(pull));
    task automatic chk(input logic ok);
        checked++;
        if (!ok) begin
            errors++;
            $display("[FAIL] %0t unexpected value", $time);
        end
    endtask : chk
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction : xs
    // read data is taken at the accepting edge, before that edge's updates land
    always @(posedge clk) begin
        if (rd === 1'h1 && wait_r === 1'h0) chk(rdata === expq.pop_front());
    end
    task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h0000_00, d};
        do begin
            @(posedge clk);
            n++;
        end while (wait_r !== 1'h0 && n < 20);
        if (n >= 20) chk(1'h0);
        wr <= 1'h0;
        rd <= 1'h0;
    endtask : bus
    task automatic rdx(input logic [1:0] a, input logic [7:0] e);
        expq.push_back({24'h0000_00, e});
        bus(1'h0, a, 8'h00);
    endtask : rdx
    task automatic settle;
        repeat (5) @(posedge clk);
    endtask : settle
    task automatic print_verdict;
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'h1;
        rdx(a_sc, 8'h00);
        rdx(a_pe, 8'h00);
        seed = xs(seed);
        bus(1'h1, 2'h3, seed[7:0]);
        rdx(2'h3, 8'h00);
        bus(1'h1, a_pe, 8'hff);
        rdx(a_pe, 8'hff);
        bus(1'h1, a_pol, seed[15:8]);
        rdx(a_pol, seed[15:8]);
        chk(pull === seed[11:8]);
        bus(1'h1, a_sc, 8'h00);
        bus(1'h1, a_pol, 8'h00);
        bus(1'h1, a_pe, 8'h0f);
        bus(1'h1, a_sc, 8'h04);
        bus(1'h1, a_sc, 8'hf2);
        be <= 4'he;
        bus(1'h1, a_sc, 8'h00);
        be <= 4'h1;
        rdx(a_sc, 8'h02);
        want <= 4'he;
        settle;
        chk(irq === 1'h1);
        rdx(a_sc, 8'h0a);
        bus(1'h1, a_sc, 8'h06);
        rdx(a_sc, 8'h02);
        chk(irq === 1'h0);
        // a second pin falling while the first is still held is not an edge
        want <= 4'hc;
        settle;
        rdx(a_sc, 8'h02);
        want <= 4'hf;
        settle;
        want <= 4'h7;
        settle;
        rdx(a_sc, 8'h0a);
        bus(1'h1, a_sc, 8'h06);
        bus(1'h1, a_pe, 8'h01);
        want <= 4'h5;
        settle;
        rdx(a_sc, 8'h02);
        bus(1'h1, a_sc, 8'h00);
        bus(1'h1, a_pol, 8'h0f);
        want <= 4'h0;
        settle;
        bus(1'h1, a_sc, 8'h06);
        ce <= 1'h0;
        want <= 4'h1;
        settle;
        chk(irq === 1'h0);
        ce <= 1'h1;
        settle;
        chk(irq === 1'h1);
        bus(1'h1, a_sc, 8'h07);
        settle;
        rdx(a_sc, 8'h0b);
        bus(1'h1, a_sc, 8'h07);
        rdx(a_sc, 8'h0b);
        want <= 4'h0;
        settle;
        bus(1'h1, a_sc, 8'h07);
        rdx(a_sc, 8'h03);
        stp <= 1'h1;
        want <= 4'h1;
        @(posedge clk);
        @(negedge clk);
        chk(wake === 1'h1);
        @(posedge clk);
        stp <= 1'h0;
        rst_b <= 1'h0;
        @(posedge clk);
        rst_b <= 1'h1;
        rdx(a_sc, 8'h00);
        rdx(a_pe, 8'h00);
        print_verdict;
    end
endmodule : kpi_key_pin_interrupt_bench
`default_nettype wire
